// File: core/cud_data_path.sv
// Purpose: Character data path of a smart-card UART
// Assumes: Host bus strobes on core_clk; card line open drain
// Notes: Register at one shared address, write transmits, read receives
//
// How it works
// R1: Transmit starts at write strobe when ready
// R2: Waits for extra guard time to expire
// R3: No start while previous character sends
// R4: Host data in direct convention, no reversal
// R5: Sync mode drives transmit lsb onto line
// R6: Sync mode read lsb mirrors line level
// R7: Receive FIFO depth programmable one to eight
// R8: Depth above one interrupts only when full
// R9: T0 parity error discards, counts error
// R10: Counter reaching limit sets flag, interrupt low
// R11: Host reloads limit after count reached
// R12: T1 parity error stored, flag set when counter at limit
// R13: Full flag set when full, cleared by read
// R14: Empty flag held while nothing received
// R15: Shared address, write tx, read rx
// R16: Empty flag clears on first stored character
`include "cud_consts.svh"
module cud_data_path import cud_pkg::*; #(
  parameter int FIFO_DEPTH = 8,
  parameter logic [15:0] ETU_CYCLES = `CUD_ETU_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Host register port
  input wire logic [3:0] addr,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Configuration
  input wire logic sync_card_select,
  input wire logic protocol_t1,
  input wire logic [3:0] fifo_depth,
  input wire logic [3:0] perr_limit,
  input wire logic perr_limit_load,
  input wire logic guard_expired,
  // Status
  output logic parity_error_flag,
  output logic rx_full_flag,
  output logic fifo_empty_flag,
  output logic tx_busy,
  output logic int_n,
  // Card line
  input wire logic io_in,
  output logic io_out,
  output logic io_oe
);
  cud_tx_e tx_st_r;
  cud_rx_e rx_st_r;
  logic io_s;
  logic [7:0] tx_character_r;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_bits_r;
  logic [15:0] tx_etu_r;
  logic tx_drive_r;
  logic [1:0] tx_echo_r;
  logic sync_bit_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_bits_r;
  logic [15:0] rx_etu_r;
  logic rx_parity_bad;
  logic rx_done;
  logic rx_push;
  logic [3:0] perr_cnt_r;
  logic perr_hit;
  logic [3:0] depth_eff;
  logic f_full;
  logic f_empty;
  logic f_in_ready;
  logic f_out_valid;
  logic [7:0] f_data;
  logic host_wr;
  logic host_rd;
  logic rx_full_r;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] cud_clamp(input logic [3:0] v, input logic [3:0] lim);
    cud_clamp = (v == 4'h0 || v > lim) ? `CUD_ONE : v;
  endfunction

  function automatic logic cud_etu_end(input logic [15:0] c);
    cud_etu_end = (c == ETU_CYCLES - 16'h0001);
  endfunction

  // ----------------------------------------
  // Input sync and decode
  // ----------------------------------------
  cud_sync2 u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .d(io_in),
    .q(io_s)
  );

  assign host_wr = wr_strobe && (addr == `CUD_CHAR_ADDR); // see R15
  assign host_rd = rd_strobe && (addr == `CUD_CHAR_ADDR); // see R15

  // ----------------------------------------
  // Transmit
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_character_r <= `CUD_CHAR_RESET;
    end else if (host_wr && tx_st_r == CUD_TX_IDLE) begin
      tx_character_r <= wdata; // see R4
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_bit_r <= 1'b1;
    end else if (host_wr && sync_card_select) begin
      sync_bit_r <= wdata[0]; // see R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_st_r <= CUD_TX_IDLE;
      tx_sh_r <= '1;
      tx_bits_r <= 4'h0;
      tx_etu_r <= 16'h0000;
    end else begin
      case (tx_st_r)
        CUD_TX_IDLE: begin
          if (host_wr && !sync_card_select) begin
            tx_st_r <= CUD_TX_WAIT; // see R1
          end
        end
        CUD_TX_WAIT: begin
          if (guard_expired && rx_st_r == CUD_RX_IDLE) begin
            tx_st_r <= CUD_TX_SEND; // see R2
            tx_sh_r <= {^tx_character_r, tx_character_r, 1'b0};
            tx_bits_r <= 4'h0;
            tx_etu_r <= 16'h0000;
          end
        end
        CUD_TX_SEND: begin
          if (cud_etu_end(tx_etu_r)) begin
            tx_etu_r <= 16'h0000;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bits_r <= tx_bits_r + `CUD_ONE;
            // Last slot is the released stop bit
            if (tx_bits_r == `CUD_TX_BITS - `CUD_ONE) begin
              tx_st_r <= CUD_TX_IDLE;
            end
          end else begin
            tx_etu_r <= tx_etu_r + 16'h0001;
          end
        end
        default: tx_st_r <= CUD_TX_IDLE;
      endcase
    end
  end

  assign tx_busy = (tx_st_r != CUD_TX_IDLE); // see R3

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_drive_r <= 1'b0;
    end else if (sync_card_select) begin
      tx_drive_r <= host_wr ? !wdata[0] : !sync_bit_r; // see R5
    end else begin
      tx_drive_r <= (tx_st_r == CUD_TX_SEND) && !tx_sh_r[0];
    end
  end

  // Open drain, only ever pulls low
  assign io_out = 1'b0;
  assign io_oe = tx_drive_r;

  // ----------------------------------------
  // Own drive echo guard
  // ----------------------------------------
  // Keeps the synced echo of our drive from posing as a start bit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_echo_r <= 2'b00;
    end else begin
      tx_echo_r <= {tx_echo_r[0], tx_drive_r};
    end
  end

  // ----------------------------------------
  // Receive
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_st_r <= CUD_RX_IDLE;
      rx_sh_r <= 9'h000;
      rx_bits_r <= 4'h0;
      rx_etu_r <= 16'h0000;
    end else begin
      case (rx_st_r)
        CUD_RX_IDLE: begin
          if (!io_s && !sync_card_select && tx_st_r != CUD_TX_SEND && !tx_drive_r && tx_echo_r == 2'b00) begin
            rx_st_r <= CUD_RX_BITS;
            rx_bits_r <= 4'h0;
            rx_etu_r <= {1'b0, ETU_CYCLES[15:1]};
          end
        end
        CUD_RX_BITS: begin
          if (cud_etu_end(rx_etu_r)) begin
            rx_etu_r <= 16'h0000;
            rx_sh_r <= {io_s, rx_sh_r[8:1]};
            rx_bits_r <= rx_bits_r + `CUD_ONE;
            if (rx_bits_r == `CUD_BIT_CNT - `CUD_ONE) begin
              rx_st_r <= CUD_RX_STOP;
            end
          end else begin
            rx_etu_r <= rx_etu_r + 16'h0001;
          end
        end
        CUD_RX_STOP: begin
          if (io_s) begin
            rx_st_r <= CUD_RX_IDLE;
          end
        end
        default: rx_st_r <= CUD_RX_IDLE;
      endcase
    end
  end

  assign rx_done = (rx_st_r == CUD_RX_BITS) && cud_etu_end(rx_etu_r)
                   && (rx_bits_r == `CUD_BIT_CNT - `CUD_ONE);
  assign rx_parity_bad = ^{io_s, rx_sh_r[8:1]};
  assign rx_push = rx_done && f_in_ready && (protocol_t1 || !rx_parity_bad); // see R9 see R12

  // ----------------------------------------
  // Parity error counting
  // ----------------------------------------
  assign perr_hit = rx_done && rx_parity_bad && (perr_cnt_r == `CUD_ONE);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      perr_cnt_r <= `CUD_ONE;
    end else if (perr_limit_load) begin
      perr_cnt_r <= cud_clamp(perr_limit, `CUD_PERR_MAX); // see R11
    end else if (rx_done && rx_parity_bad && perr_cnt_r > `CUD_ONE) begin
      perr_cnt_r <= perr_cnt_r - `CUD_ONE; // see R9
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      parity_error_flag <= 1'b0;
    end else if (perr_hit) begin
      parity_error_flag <= 1'b1; // see R10 see R12
    end else if (perr_limit_load) begin
      parity_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive FIFO and flags
  // ----------------------------------------
  assign depth_eff = cud_clamp(fifo_depth, `CUD_FIFO_MAX); // see R7

  cud_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .limit(depth_eff),
    .in_valid(rx_push),
    .in_ready(f_in_ready),
    .in_data(rx_sh_r[8:1]), // see R4
    .out_valid(f_out_valid),
    .out_ready(host_rd),
    .out_data(f_data),
    .full(f_full),
    .empty(f_empty)
  );

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_full_r <= 1'b0;
    end else if (f_full && !(host_rd && f_out_valid)) begin
      rx_full_r <= 1'b1; // see R13
    end else if (host_rd && f_out_valid) begin
      rx_full_r <= 1'b0; // see R13
    end
  end

  assign rx_full_flag = rx_full_r;
  assign fifo_empty_flag = f_empty; // see R14 see R16
  assign int_n = !(parity_error_flag || rx_full_r); // see R8 see R10

  // ----------------------------------------
  // Host read data
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata <= `CUD_CHAR_RESET;
    end else if (host_rd) begin
      rdata <= sync_card_select ? {7'h00, io_s} : (f_out_valid ? f_data : rdata); // see R6 see R15
    end
  end
endmodule

// File: core/cud_consts.svh
// Purpose: Constants for the card UART data path
// Assumes: 125 MHz core clock
// Notes: Included by the data path and FIFO design files
`ifndef CUD_CONSTS_SVH
`define CUD_CONSTS_SVH
`define CUD_CHAR_ADDR 4'hd
`define CUD_CHAR_RESET 8'h00
`define CUD_FIFO_MAX 4'h8
`define CUD_PERR_MAX 4'h8
`define CUD_BIT_CNT 4'ha
`define CUD_TX_BITS 4'hb
`define CUD_ONE 4'h1
`define CUD_ETU_DEF 16'h0174
`endif

// File: core/cud_pkg.sv
// Purpose: Types for the card UART data path
// Assumes: Nothing
// Notes: States of transmit and receive engines
package cud_pkg;
  typedef enum logic [1:0] {CUD_TX_IDLE, CUD_TX_WAIT, CUD_TX_SEND} cud_tx_e;
  typedef enum logic [1:0] {CUD_RX_IDLE, CUD_RX_BITS, CUD_RX_STOP} cud_rx_e;
endpackage

// File: core/cud_sync2.sv
// Purpose: Two flip-flop synchroniser for the card line
// Assumes: Single core clock
// Notes: First stage read only by the second
module cud_sync2 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Data
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// File: core/cud_fifo.sv
// Purpose: Receive character FIFO with live depth limit
// Assumes: Depth limit between 1 and DEPTH
// Notes: Full follows the programmed limit
`include "cud_consts.svh"
module cud_fifo import cud_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Depth limit
  input wire logic [3:0] limit,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [3:0] cnt_r;
  logic push;
  logic pop;

  assign full = (cnt_r >= limit);
  assign empty = (cnt_r == 4'h0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_r];

  function automatic logic [AW-1:0] cud_inc(input logic [AW-1:0] p);
    cud_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= 4'h0;
    end else begin
      if (push) begin
        wr_r <= cud_inc(wr_r);
      end
      if (pop) begin
        rd_r <= cud_inc(rd_r);
      end
      cnt_r <= cnt_r + (push ? `CUD_ONE : 4'h0) - (pop ? `CUD_ONE : 4'h0);
    end
  end
endmodule

// File: testbench/cud_data_path_monitor.sv
// Purpose: Port checker for the card UART data path
// Assumes: Sees top module ports only
// Notes: Bound after the module
module cud_data_path_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Host side
  input wire logic [3:0] addr,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic sync_card_select,
  // Status and line
  input wire logic parity_error_flag,
  input wire logic rx_full_flag,
  input wire logic fifo_empty_flag,
  input wire logic tx_busy,
  input wire logic int_n,
  input wire logic io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  rd_keep_a: assert property (rd_strobe && addr != 4'hd |=> $stable(rdata)) else $error("rdata moved");
  empty_rise_a: assert property ($rose(fifo_empty_flag) |-> $past(rd_strobe && addr == 4'hd)) else $error("empty");
  full_fall_a: assert property ($fell(rx_full_flag) |-> $past(rd_strobe && addr == 4'hd)) else $error("full");
  full_empty_a: assert property (rx_full_flag |-> !fifo_empty_flag) else $error("full and empty");
  int_full_a: assert property (rx_full_flag |-> !int_n) else $error("no full interrupt");
  int_perr_a: assert property (parity_error_flag |-> !int_n) else $error("no parity interrupt");
  int_cause_a: assert property (!int_n |-> rx_full_flag || parity_error_flag) else $error("stray interrupt");
  sync_drive_a: assert property (sync_card_select && wr_strobe && addr == 4'hd |=> io_oe == !$past(wdata[0]))
    else $error("sync drive");
  tx_end_a: assert property ($fell(tx_busy) |-> !io_oe) else $error("line held at end");
  cover property (rx_full_flag);
  cover property (parity_error_flag);
  cover property (sync_card_select && io_oe);
endmodule
bind cud_data_path cud_data_path_monitor i_mon (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .wdata(wdata), .rdata(rdata), .sync_card_select(sync_card_select), .tx_busy(tx_busy),
  .parity_error_flag(parity_error_flag), .rx_full_flag(rx_full_flag), .fifo_empty_flag(fifo_empty_flag),
  .int_n(int_n), .io_oe(io_oe));

// File: testbench/cud_card_model.sv
// Purpose: Card on the single I/O line
// Assumes: Open drain line with pull-up
// Notes: One framed character per go pulse
module cud_card_model #(
  parameter int ETU = 4
) (
  // Control
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] char_in,
  input wire logic bad_par,
  input wire logic hold,
  // Line drive
  output logic card_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic frame_oe = 1'b0;
  logic [11:0] bits;
  assign card_oe = frame_oe || hold;
  always @(posedge go) begin
    bits = {2'b11, ^char_in ^ bad_par, char_in, 1'b0};
    @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      frame_oe <= !bits[i];
      repeat (ETU) @(posedge core_clk);
    end
  end
endmodule

// File: testbench/card_uart_data_path_bench.sv
// Purpose: Self-checking bench of the card UART data path
// Assumes: Bit time cut to four cycles
// Notes: Reads checked through a queue
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module card_uart_data_path_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ETU = 4;
  logic core_clk = 0, nrst = 0, wr_strobe = 0, rd_strobe = 0, sync_card_select = 0, protocol_t1 = 0;
  logic perr_limit_load = 0, guard_expired = 0, go = 0, bad = 0, hold = 0, rd_pend = 0;
  logic [3:0] addr = 4'hd, fifo_depth = 4'h2, perr_limit = 4'h1;
  logic [7:0] wdata = 8'h00, rdata, cc = 8'h00, c0, c1, ex;
  logic parity_error_flag, rx_full_flag, fifo_empty_flag, tx_busy, int_n, io_out, io_oe, card_oe;
  logic [9:0] fr;
  logic [7:0] exp_q[$];
  int n_mismatch = 0, checks = 0, seed = 66, k;
  wire io_line = !(io_oe || card_oe);
  always #4 core_clk = ~core_clk;
  cud_data_path #(.FIFO_DEPTH(8), .ETU_CYCLES(16'h0004)) i_dut (.core_clk(core_clk), .nrst(nrst), .addr(addr),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wdata(wdata), .rdata(rdata), .sync_card_select(sync_card_select),
    .protocol_t1(protocol_t1), .fifo_depth(fifo_depth), .perr_limit(perr_limit), .perr_limit_load(perr_limit_load),
    .guard_expired(guard_expired), .parity_error_flag(parity_error_flag), .rx_full_flag(rx_full_flag),
    .fifo_empty_flag(fifo_empty_flag), .tx_busy(tx_busy), .int_n(int_n), .io_in(io_line), .io_out(io_out),
    .io_oe(io_oe));
  cud_card_model #(.ETU(ETU)) i_card (.core_clk(core_clk), .go(go), .char_in(cc), .bad_par(bad), .hold(hold),
    .card_oe(card_oe));
  always @(posedge core_clk) rd_pend <= rd_strobe && addr == 4'hd;
  always @(negedge core_clk) if (rd_pend && exp_q.size() > 0) begin
    ex = exp_q.pop_front();
    `CHK("rdata", ex, rdata)
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge core_clk);
    wdata = d;
    wr_strobe = 1;
    @(negedge core_clk);
    wr_strobe = 0;
  endtask
  task automatic rd(input logic [7:0] e, input logic q);
    if (q) exp_q.push_back(e);
    @(negedge core_clk);
    rd_strobe = 1;
    @(negedge core_clk);
    rd_strobe = 0;
  endtask
  task automatic send(input logic [7:0] c, input logic b);
    @(negedge core_clk);
    cc = c;
    bad = b;
    go = 1;
    @(negedge core_clk);
    go = 0;
    tick(14 * ETU);
  endtask
  task automatic load(input logic [3:0] l);
    @(negedge core_clk);
    perr_limit = l;
    perr_limit_load = 1;
    @(negedge core_clk);
    perr_limit_load = 0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    tick(6);
    nrst = 1;
    tick(3);
    `CHK("rdata reset", 8'h00, rdata)
    `CHK("empty reset", 1'b1, fifo_empty_flag)
    rd(8'h00, 1);
    c0 = $random(seed);
    fr = {^c0, c0, 1'b0};
    wr(c0);
    wr(~c0);
    tick(20);
    `CHK("busy", 1'b1, tx_busy)
    `CHK("oe wait", 1'b0, io_oe)
    guard_expired = 1;
    k = 0;
    while (!io_oe && k < 50) begin
      tick(1);
      k++;
    end
    if (k == 50) begin
      n_mismatch++;
      results();
    end
    tick(ETU / 2);
    for (int i = 0; i < 10; i++) begin
      `CHK("line bit", fr[i], io_line)
      tick(ETU);
    end
    tick(ETU);
    `CHK("busy end", 1'b0, tx_busy)
    for (int i = 0; i < 10; i++) begin
      `CHK("no second", 1'b0, io_oe)
      tick(ETU);
    end
    $display("test transmit done");
    c0 = $random(seed);
    c1 = $random(seed);
    send(c0, 0);
    `CHK("empty", 1'b0, fifo_empty_flag)
    `CHK("int early", 1'b1, int_n)
    send(c1, 0);
    `CHK("full", 1'b1, rx_full_flag)
    `CHK("int full", 1'b0, int_n)
    rd(c0, 1);
    tick(1);
    `CHK("full clear", 1'b0, rx_full_flag)
    rd(c1, 1);
    tick(1);
    `CHK("empty again", 1'b1, fifo_empty_flag)
    fifo_depth = 4'h1;
    send(c1, 0);
    `CHK("full depth one", 1'b1, rx_full_flag)
    rd(c1, 1);
    fifo_depth = 4'h8;
    $display("test receive done");
    load(4'h2);
    send(c0, 1);
    `CHK("discard", 1'b1, fifo_empty_flag)
    `CHK("perr early", 1'b0, parity_error_flag)
    send(c1, 1);
    `CHK("perr", 1'b1, parity_error_flag)
    `CHK("int perr", 1'b0, int_n)
    load(4'h1);
    tick(1);
    `CHK("perr reload", 1'b0, parity_error_flag)
    protocol_t1 = 1;
    send(c0, 1);
    `CHK("t1 stored", 1'b0, fifo_empty_flag)
    `CHK("t1 perr", 1'b1, parity_error_flag)
    rd(c0, 1);
    load(4'h1);
    $display("test parity done");
    protocol_t1 = 0;
    sync_card_select = 1;
    wr(8'hfe);
    `CHK("sync low", 1'b1, io_oe)
    wr(8'h01);
    `CHK("sync high", 1'b0, io_oe)
    hold = 1;
    tick(4);
    rd(8'h00, 1);
    `CHK("sync read low", 1'b0, rdata[0])
    hold = 0;
    tick(4);
    rd(8'h01, 1);
    `CHK("sync read high", 1'b1, rdata[0])
    `CHK("io out", 1'b0, io_out)
    $display("test sync done");
    addr = 4'h3;
    rd(8'h00, 0);
    `CHK("rdata kept", 8'h01, rdata)
    wr(8'h00);
    `CHK("wrong addr", 1'b0, io_oe)
    addr = 4'hd;
    $display("test address done");
    results();
  end
endmodule
